// [bench/fail_mode_supervisor_tb_top.sv]
// self-checking bench of the fail mode supervisor
`timescale 1ns/1ns
`include "fms_regs.svh"
module fail_mode_supervisor_tb_top;
  import fms_pkg::*;
  localparam int WD0 = 2000;
  localparam int WD1 = 4000;
  localparam int DGL = 20;
  localparam int CLKLOW = 300;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wd;
    logic [1:0] resp;
    logic [7:0] rd;
    logic       esd;
  } fms_row_t;
  logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, direct_channel_input, channel_pwm, channel_on;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  fms_spi_t    spi_pins;
  logic        fail_force, pwm_clk, reset_pin_n, external_switch_drive;
  logic        fail_mode, go, tog, busy, last_tog;
  logic [5:0]  nbits;
  int          bad_count, n_compared, pclk_half;
  fms_row_t    rows [6] = '{
    '{`FMS_ADDR_CTRL, 8'h04, `FMS_RESP_OKAY, 8'h04, 1'h1},
    '{`FMS_ADDR_CTRL, 8'hF0, `FMS_RESP_OKAY, 8'hF0, 1'h0},
    '{8'h08, 8'h04, `FMS_RESP_SLVERR, 8'h00, 1'h0},
    '{`FMS_ADDR_DSTAT, 8'hFF, `FMS_RESP_OKAY, 8'h00, 1'h0},
    '{`FMS_ADDR_CTRL, 8'h06, `FMS_RESP_OKAY, 8'h06, 1'h0},
    '{`FMS_ADDR_CTRL, 8'h04, `FMS_RESP_OKAY, 8'h04, 1'h1}};

  fms_supervisor #(.WD0_CYC(WD0), .WD1_CYC(WD1), .DGL_CYC(DGL),
    .RST_DGL_CYC(10), .CLK_DGL_CYC(4), .CLK_LOW_CYC(CLKLOW))
  fms_supervisor_inst (.clock, .rstn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .spi_pins, .fail_force,
    .direct_channel_input, .pwm_clk, .reset_pin_n, .channel_pwm,
    .channel_on, .external_switch_drive, .fail_mode);
  fms_host_model fms_host_model_inst (.clock, .go, .nbits, .tog,
    .spi(spi_pins), .busy);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  initial begin
    forever begin
      @(posedge clock);
      if (pclk_half != 0) begin
        repeat (pclk_half - 1) @(posedge clock);
        pwm_clk <= ~pwm_clk;
      end
    end
  end
  initial begin
    #500000;
    bad_count++;
    $display("MISMATCH at %0t: run too long", $time);
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic axi_write(input logic [7:0] a, input logic [31:0] dv,
                           output logic [1:0] r);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= dv;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    r = bresp;
    bready <= 1'h0;
    if (n >= 100) check(1'h0, 1'h1);
    cyc(1);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] dv,
                          output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    dv = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n >= 100) check(1'h0, 1'h1);
    cyc(1);
  endtask : axi_read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] dv;
    logic [1:0]  r;
    axi_read(a, dv, r);
    check({r, dv}, {`FMS_RESP_OKAY, 24'h0, e});
  endtask : rd_chk
  task automatic frame(input logic [5:0] n, input logic t);
    int k;
    k = 0;
    nbits <= n;
    tog   <= t;
    go    <= 1'h1;
    cyc(1);
    go <= 1'h0;
    cyc(1);
    while (busy && k < 1000) begin
      cyc(1);
      k++;
    end
    cyc(12);
  endtask : frame
  task automatic good;
    last_tog = ~last_tog;
    frame(16, last_tog);
  endtask : good
  task automatic wait_fail(input logic e, input int lim);
    int k;
    k = 0;
    while (fail_mode !== e && k < lim) begin
      cyc(1);
      k++;
    end
    check(fail_mode, e);
  endtask : wait_fail

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0]  r;
    logic [31:0] dv;
    {rstn, awvalid, wvalid, bready, arvalid, rready, go, tog} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {fail_force, pwm_clk, reset_pin_n, last_tog} = 4'h0;
    wstrb = 4'hF;
    direct_channel_input = 4'h9;
    channel_pwm = 4'h5;
    nbits = 6'h10;
    {pclk_half, bad_count, n_compared} = '0;
    cyc(2);
    check({awready, arready, fail_mode, channel_on}, 7'h00);
    rstn <= 1'h1;
    cyc(4);
    foreach (rows[i]) begin
      axi_write(rows[i].addr, {24'h0, rows[i].wd}, r);
      check(r, rows[i].resp);
      axi_read(rows[i].addr, dv, r);
      check({r, dv}, {rows[i].resp, 24'h0, rows[i].rd});
      check(external_switch_drive, rows[i].esd);
    end
    wstrb <= 4'h0;
    axi_write(`FMS_ADDR_CTRL, 32'h000000F1, r);
    check(r, `FMS_RESP_OKAY);
    rd_chk(`FMS_ADDR_CTRL, 8'h04);
    wstrb <= 4'hF;
    reset_pin_n <= 1'h1;
    cyc(20);
    good();
    wait_fail(1'h0, 5);
    frame(16, last_tog);
    wait_fail(1'h1, 20);
    rd_chk(`FMS_ADDR_DSTAT, 8'h0E);
    rd_chk(`FMS_ADDR_DSTAT, 8'h0E);
    check(channel_on, 4'h9);
    check(external_switch_drive, 1'h0);
    good();
    wait_fail(1'h0, 20);
    rd_chk(`FMS_ADDR_DSTAT, 8'h00);
    check(external_switch_drive, 1'h1);
    frame(17, ~last_tog);
    wait_fail(1'h1, 20);
    good();
    wait_fail(1'h0, 20);
    cyc(WD0 - 400);
    check(fail_mode, 1'h0);
    wait_fail(1'h1, 600);
    good();
    axi_write(`FMS_ADDR_CTRL, 32'h05, r);
    cyc(WD0);
    check(fail_mode, 1'h0);
    wait_fail(1'h1, WD1 - WD0 + 200);
    good();
    wait_fail(1'h0, 20);
    fail_force <= 1'h1;
    cyc(DGL / 2);
    fail_force <= 1'h0;
    cyc(DGL * 2);
    check(fail_mode, 1'h0);
    fail_force <= 1'h1;
    cyc(DGL - 4);
    check(fail_mode, 1'h0);
    wait_fail(1'h1, 20);
    rd_chk(`FMS_ADDR_DSTAT, 8'h05);
    fail_force <= 1'h0;
    wait_fail(1'h0, DGL + 10);
    good();
    axi_write(`FMS_ADDR_CTRL, 32'hA5, r);
    cyc(3);
    check(channel_on, 4'hA);
    pclk_half = 10;
    cyc(60);
    check(channel_on, 4'h5);
    rd_chk(`FMS_ADDR_QSTAT, 8'h01);
    rd_chk(`FMS_ADDR_QSTAT, 8'h00);
    pclk_half = 2;
    cyc(CLKLOW + 50);
    check(channel_on, 4'hA);
    rd_chk(`FMS_ADDR_QSTAT, 8'h03);
    rstn <= 1'h0;
    cyc(2);
    check({bvalid, rvalid, fail_mode, external_switch_drive, channel_on},
          8'h00);
    rstn <= 1'h1;
    cyc(4);
    rd_chk(`FMS_ADDR_QSTAT, 8'h00);
    rd_chk(`FMS_ADDR_CTRL, 8'h00);
    print_verdict();
  end
endmodule : fail_mode_supervisor_tb_top

// [bench/fms_host_model.sv]
// host side model: drives link frames on request
`timescale 1ns/1ns
module fms_host_model (
  input  wire logic         clock,
  input  wire logic         go,
  input  wire logic [5:0]   nbits,
  input  wire logic         tog,
  output fms_pkg::fms_spi_t spi,
  output logic              busy
);
  import fms_pkg::*;
  initial begin
    spi  = '{sclk: 1'h0, csb_n: 1'h1, mosi: 1'h0};
    busy = 1'h0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy      <= 1'h1;
        spi.csb_n <= 1'h0;
        repeat (8) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
          spi.mosi <= (i == 0) ? tog : i[0];
          repeat (8) @(posedge clock);
          spi.sclk <= 1'h1;
          repeat (8) @(posedge clock);
          spi.sclk <= 1'h0;
        end
        repeat (8) @(posedge clock);
        spi.csb_n <= 1'h1;
        busy      <= 1'h0;
      end else begin
        spi.mosi <= ~spi.mosi;
      end
    end
  end
endmodule : fms_host_model

// [shared/fms_pkg.sv]
// types of the fail mode supervisor
package fms_pkg;
  typedef struct packed {
    logic sclk;
    logic csb_n;
    logic mosi;
  } fms_spi_t;

  typedef struct packed {
    logic [23:0] cnt;
    logic        out;
  } fms_dgl_t;

  typedef struct packed {
    logic [9:0]  sy1;
    logic [9:0]  sy2;
    logic [1:0]  sprev;
    logic [3:0]  bitcnt;
    logic        anybit;
    logic        first;
    logic        last_tog;
    logic [23:0] wd_cnt;
    logic        link_fault;
    logic        lerr;
    logic        fail;
    logic [23:0] ck_cnt;
    logic        ck_prev;
    logic        clk_bad;
    logic        clk_fail;
    logic [7:0]  ctrl;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic [3:0]  chan_on;
    logic        ext;
  } fms_state_t;
endpackage : fms_pkg

// [shared/fms_regs.svh]
// register map, field positions and timing constants of the supervisor
`ifndef FMS_REGS_SVH
`define FMS_REGS_SVH
`define FMS_CLK_MHZ     100
`define FMS_ADDR_CTRL   8'h00
`define FMS_ADDR_QSTAT  8'h04
`define FMS_ADDR_DSTAT  8'h1C
`define FMS_CTRL_RST    8'h00
`define FMS_CTRL_TSEL   0
`define FMS_CTRL_SLEEP  1
`define FMS_CTRL_CH6    2
`define FMS_CTRL_CHLSB  4
`define FMS_QSTAT_CLKF  0
`define FMS_QSTAT_CLKB  1
`define FMS_DSTAT_LIMP  0
`define FMS_DSTAT_LERR  1
`define FMS_DSTAT_FAIL  2
`define FMS_DSTAT_LFLT  3
`define FMS_RESP_OKAY   2'h0
`define FMS_RESP_SLVERR 2'h2
`define FMS_SY_SCLK     0
`define FMS_SY_CSB      1
`define FMS_SY_MOSI     2
`define FMS_SY_LIMP     3
`define FMS_SY_IN       4
`define FMS_SY_PCLK     8
`define FMS_SY_RST      9
`define FMS_WD0_MS      32
`define FMS_WD1_MS      128
`define FMS_DGL_US      200
`define FMS_RST_DGL_US  10
`define FMS_CLK_DGL_NS  2000
`define FMS_CLK_LOW_HZ  100
`define FMS_WD0_CYC     (`FMS_WD0_MS * 1000 * `FMS_CLK_MHZ)
`define FMS_WD1_CYC     (`FMS_WD1_MS * 1000 * `FMS_CLK_MHZ)
`define FMS_DGL_CYC     (`FMS_DGL_US * `FMS_CLK_MHZ)
`define FMS_RST_DGL_CYC (`FMS_RST_DGL_US * `FMS_CLK_MHZ)
`define FMS_CLK_DGL_CYC (`FMS_CLK_DGL_NS * `FMS_CLK_MHZ / 1000)
`define FMS_CLK_LOW_CYC (`FMS_CLK_MHZ * 1000000 / `FMS_CLK_LOW_HZ)
`endif

// [src/fms_deglitch.sv]
// deglitch filter for one synchronised input
`timescale 1ns/1ns
module fms_deglitch #(
  parameter int CYC       = 20000,
  parameter bit FALL_ONLY = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  import fms_pkg::*;

  localparam logic [23:0] LIM = 24'(CYC - 1);

  if (CYC < 1 || CYC >= 2**24) begin : g_bad
    $error("deglitch count out of range");
  end

  fms_dgl_t s;
  fms_dgl_t n;

  always_comb begin
    n = s;
    if (din == s.out) begin
      n.cnt = 24'h000000;
    end else if (FALL_ONLY && din) begin
      n.out = 1'b1; // R13
      n.cnt = 24'h000000;
    end else if (s.cnt >= LIM) begin
      n.out = din; // R10
      n.cnt = 24'h000000;
    end else begin
      n.cnt = s.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dout = s.out;

  //////////////////////////////////////////////////////////////////////////
  a_dgl_stable: assert property (@(posedge clock) disable iff (!rst_n) // R10
    ($changed(s.out) && !(FALL_ONLY && s.out)) |->
      $past(din, 1) == s.out && $past(s.cnt) == LIM)
    else $error("filter output changed before input was stable");
  a_dgl_rise: assert property (@(posedge clock) disable iff (!rst_n) // R13
    (FALL_ONLY && din && !s.out) |=> s.out)
    else $error("rising edge delayed by fall-only filter");
endmodule : fms_deglitch

// [src/fms_supervisor.sv]
// fail mode supervisor: link watchdog, input filters, clock monitor
// Operation
// (R01) filtered fail-force input high puts the device in fail mode
// (R02) in fail mode each channel follows its filtered direct input
// (R03) fail-force level readable in device status register
// (R04) any link error switches the device into fail mode
// (R05) frame with untoggled toggle bit is a link fault
// (R06) no good frame within 32 ms or 128 ms is a link fault
// (R07) frame bit count not multiple of sixteen is a link fault
// (R08) link fault sets link error flag, readable in next exchange
// (R09) link error flag holds in fail mode, clears on leaving it
// (R10) fail-force and direct inputs filtered symmetrically by 200 us
// (R11) filtered fail request rises after input high 200 us
// (R12) direct input high 200 us asserts filtered channel input
// (R13) reset pin filtered 10 us on falling edge only
// (R14) clock input filtered 2 us; too fast clock reads as failed
// (R15) clock monitor starts at reset rise; slow clock uses control bits
// (R16) valid clock lets channels follow the pwm duty setting
// (R17) clock fail latched until condition gone and quick status read
// (R18) external switch drive follows channel six setting in normal mode
// (R19) external switch drive off in sleep and fail mode
// (R20) lost logic supply silences the link and ends in watchdog timeout
// (R21) watchdog restarts on each good frame with toggled bit
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "fms_regs.svh"
module fms_supervisor #(
  parameter int WD0_CYC     = `FMS_WD0_CYC,
  parameter int WD1_CYC     = `FMS_WD1_CYC,
  parameter int DGL_CYC     = `FMS_DGL_CYC,
  parameter int RST_DGL_CYC = `FMS_RST_DGL_CYC,
  parameter int CLK_DGL_CYC = `FMS_CLK_DGL_CYC,
  parameter int CLK_LOW_CYC = `FMS_CLK_LOW_CYC
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  input  wire fms_pkg::fms_spi_t spi_pins,
  input  wire logic             fail_force,
  input  wire logic [3:0]       direct_channel_input,
  input  wire logic             pwm_clk,
  input  wire logic             reset_pin_n,
  input  wire logic [3:0]       channel_pwm,
  output logic [3:0]            channel_on,
  output logic                  external_switch_drive,
  output logic                  fail_mode
);
  import fms_pkg::*;

  localparam logic [23:0] WD0_L = 24'(WD0_CYC - 1);
  localparam logic [23:0] WD1_L = 24'(WD1_CYC - 1);
  localparam logic [23:0] CKL_L = 24'(CLK_LOW_CYC - 1);

  if (WD0_CYC < 2 || WD1_CYC < 2 || CLK_LOW_CYC < 2 ||
      WD0_CYC >= 2**24 || WD1_CYC >= 2**24 ||
      CLK_LOW_CYC >= 2**24) begin : g_bad
    $error("supervisor count out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sy;
  logic       rst_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sy <= 2'h0;
    end else begin
      rst_sy <= {rst_sy[0], 1'b1};
    end
  end

  assign rst_n = rst_sy[1];

  //////////////////////////////////////////////////////////////////////////
  // input filters
  fms_state_t s;
  fms_state_t n;
  logic       limp_f;
  logic [3:0] in_f;
  logic       pclk_f;
  logic       rst_f;

  fms_deglitch #(
    .CYC       (DGL_CYC),
    .FALL_ONLY (1'b0)
  ) u_limp (
    .clock (clock),
    .rst_n (rst_n),
    .din   (s.sy2[`FMS_SY_LIMP]),
    .dout  (limp_f)
  ); // R11

  for (genvar i = 0; i < 4; i++) begin : g_in
    fms_deglitch #(
      .CYC       (DGL_CYC),
      .FALL_ONLY (1'b0)
    ) u_in (
      .clock (clock),
      .rst_n (rst_n),
      .din   (s.sy2[`FMS_SY_IN + i]),
      .dout  (in_f[i])
    ); // R12
  end

  fms_deglitch #(
    .CYC       (CLK_DGL_CYC),
    .FALL_ONLY (1'b0)
  ) u_pclk (
    .clock (clock),
    .rst_n (rst_n),
    .din   (s.sy2[`FMS_SY_PCLK]),
    .dout  (pclk_f)
  ); // R14

  fms_deglitch #(
    .CYC       (RST_DGL_CYC),
    .FALL_ONLY (1'b1)
  ) u_rst (
    .clock (clock),
    .rst_n (rst_n),
    .din   (s.sy2[`FMS_SY_RST]),
    .dout  (rst_f)
  ); // R13

  //////////////////////////////////////////////////////////////////////////
  // next state
  logic        sclk;
  logic        csb;
  logic        mosi;
  logic        sclk_rise;
  logic        cs_rise;
  logic        fault;
  logic        good;
  logic        qread;
  logic [23:0] wd_lim;

  always_comb begin
    n = s;
    n.sy1 = {reset_pin_n, pwm_clk, direct_channel_input, fail_force,
             spi_pins.mosi, spi_pins.csb_n, spi_pins.sclk};
    n.sy2 = s.sy1;
    sclk = s.sy2[`FMS_SY_SCLK];
    csb = s.sy2[`FMS_SY_CSB];
    mosi = s.sy2[`FMS_SY_MOSI];
    n.sprev = {csb, sclk};
    sclk_rise = sclk && !s.sprev[0];
    cs_rise = csb && !s.sprev[1];
    fault = 1'b0;
    good = 1'b0;
    qread = 1'b0;
    wd_lim = s.ctrl[`FMS_CTRL_TSEL] ? WD1_L : WD0_L;
    // frame check
    if (!csb && sclk_rise) begin
      if (!s.anybit) begin
        n.first = mosi;
      end
      n.anybit = 1'b1;
      n.bitcnt = s.bitcnt + 4'h1;
    end
    if (cs_rise) begin
      n.bitcnt = 4'h0;
      n.anybit = 1'b0;
      if (s.anybit) begin
        if (s.bitcnt != 4'h0) begin
          fault = 1'b1; // R07
        end else if (s.first == s.last_tog) begin
          fault = 1'b1; // R05
        end else begin
          good = 1'b1;
          n.last_tog = s.first;
        end
      end
    end
    // watchdog
    if (good) begin
      n.wd_cnt = 24'h000000; // R21
    end else if (s.wd_cnt >= wd_lim) begin
      fault = 1'b1; // R06 R20
      n.wd_cnt = 24'h000000;
    end else begin
      n.wd_cnt = s.wd_cnt + 24'h000001;
    end
    // clock monitor
    n.ck_prev = pclk_f;
    if (pclk_f && !s.ck_prev) begin
      n.ck_cnt = 24'h000000;
      n.clk_bad = 1'b0;
    end else if (s.ck_cnt >= CKL_L) begin
      n.clk_bad = 1'b1; // R14
    end else begin
      n.ck_cnt = s.ck_cnt + 24'h000001;
    end
    if (!rst_f) begin
      n.bitcnt = 4'h0;
      n.anybit = 1'b0;
      n.wd_cnt = 24'h000000;
      n.ck_cnt = 24'h000000; // R15
      n.clk_bad = 1'b0;
    end
    // register writes
    if (awvalid && s.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_have = 1'b1;
      n.w_data = wdata[7:0];
      n.w_strb0 = wstrb[0];
    end
    if (bready && s.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_have && n.w_have && !n.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `FMS_RESP_OKAY;
      unique case (n.aw_addr)
        `FMS_ADDR_CTRL: begin
          if (n.w_strb0) begin
            n.ctrl = n.w_data;
          end
        end
        `FMS_ADDR_QSTAT, `FMS_ADDR_DSTAT: begin
        end
        default: begin
          n.bresp = `FMS_RESP_SLVERR;
        end
      endcase
    end
    // register reads
    if (rready && s.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `FMS_RESP_OKAY;
      n.rdata = 8'h00;
      unique case (araddr)
        `FMS_ADDR_CTRL: begin
          n.rdata = s.ctrl;
        end
        `FMS_ADDR_QSTAT: begin
          qread = 1'b1;
          n.rdata[`FMS_QSTAT_CLKF] = s.clk_fail;
          n.rdata[`FMS_QSTAT_CLKB] = s.clk_bad;
        end
        `FMS_ADDR_DSTAT: begin
          n.rdata[`FMS_DSTAT_LIMP] = limp_f; // R03
          n.rdata[`FMS_DSTAT_LERR] = s.lerr; // R08
          n.rdata[`FMS_DSTAT_FAIL] = s.fail;
          n.rdata[`FMS_DSTAT_LFLT] = s.link_fault;
        end
        default: begin
          n.rresp = `FMS_RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;
    // fail mode and flags
    n.clk_fail = s.clk_bad || (s.clk_fail && !qread); // R17
    n.link_fault = fault || (s.link_fault && !good); // R04
    n.fail = limp_f || n.link_fault; // R01
    n.lerr = fault || (s.lerr && n.fail); // R08 R09
    // outputs
    if (n.fail) begin
      n.chan_on = in_f; // R02
    end else if (s.clk_bad) begin
      n.chan_on = s.ctrl[`FMS_CTRL_CHLSB +: 4]; // R15
    end else begin
      n.chan_on = channel_pwm; // R16
    end
    n.ext = !n.fail && !s.ctrl[`FMS_CTRL_SLEEP] &&
            s.ctrl[`FMS_CTRL_CH6]; // R18 R19
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign awready               = s.awready;
  assign wready                = s.wready;
  assign bvalid                = s.bvalid;
  assign bresp                 = s.bresp;
  assign arready               = s.arready;
  assign rvalid                = s.rvalid;
  assign rresp                 = s.rresp;
  assign rdata                 = {24'h000000, s.rdata};
  assign channel_on            = s.chan_on;
  assign external_switch_drive = s.ext;
  assign fail_mode             = s.fail;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_limp_fail: assert property (limp_f |=> fail_mode) // R01
    else $error("fail request did not enter fail mode");
  a_fail_direct: assert property ( // R02
    fail_mode |-> channel_on == $past(in_f))
    else $error("fail mode channel not from direct input");
  a_limp_read: assert property ((arvalid && arready && // R03
    araddr == `FMS_ADDR_DSTAT) |=> rvalid && rdata[0] == $past(limp_f))
    else $error("fail-force level misreported");
  a_fault_flag: assert property (fault |=> s.lerr && fail_mode) // R04
    else $error("link fault did not set flag and fail mode");
  a_toggle_err: assert property ((cs_rise && s.anybit && // R05
    s.bitcnt == 4'h0 && s.first == s.last_tog) |-> fault)
    else $error("untoggled frame not flagged");
  a_wd_timeout: assert property ((!good && rst_f && // R06
    s.wd_cnt == wd_lim) |=> s.link_fault && s.wd_cnt == 24'h000000)
    else $error("watchdog timeout not flagged");
  a_len_err: assert property ((cs_rise && s.anybit && // R07
    s.bitcnt != 4'h0) |=> s.link_fault)
    else $error("length error not flagged");
  a_flag_hold: assert property ((s.lerr && n.fail) |=> s.lerr) // R09
    else $error("link error flag lost in fail mode");
  a_flag_clear: assert property ($fell(s.fail) |-> !s.lerr) // R09
    else $error("link error flag kept after fail mode");
  a_ext_off: assert property ((fail_mode || // R19
    $past(s.ctrl[`FMS_CTRL_SLEEP])) |-> !external_switch_drive)
    else $error("external switch drive on in fail or sleep");
  a_clk_latch: assert property ((s.clk_bad || // R17
    (s.clk_fail && !qread)) |=> s.clk_fail)
    else $error("clock fail diagnosis not latched");
  a_wd_restart: assert property (good |=> // R21
    s.wd_cnt == 24'h000000 && !s.link_fault)
    else $error("good frame did not restart watchdog");

  c_good_frame: cover property (good ##1 !fail_mode);
  c_link_fault: cover property (fault ##1 fail_mode);
  c_recover: cover property (s.lerr ##[1:1000] !s.lerr);
  c_clk_fail: cover property (s.clk_bad ##1 s.clk_fail);
endmodule : fms_supervisor
